/* slcc_pkg.sv */
// Purpose: Shared types of the sleep clock calibration block.
// Assumes: slcc_regs.svh gives the address width.
// Notes: Types only.
`default_nettype none
`include "slcc_regs.svh"

package slcc_pkg;

	typedef struct packed {
		logic [`SLCC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} slcc_bus_req_t;

	typedef enum logic [1:0] {
		SLCC_IDLE,
		SLCC_ALIGN,
		SLCC_MEASURE
	} slcc_state_t;

endpackage

`default_nettype wire

/* slcc_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing figures of the sleep clock calibration block.
// Assumes: Byte-wide registers on a 10-bit register address.
// Notes: Definitions only.
`ifndef SLCC_REGS_SVH
`define SLCC_REGS_SVH

`define SLCC_ADDR_W 10
`define SLCC_OFS_SRC_SEL 10'h207
`define SLCC_OFS_TUNE 10'h208
`define SLCC_OFS_CNT_LO 10'h209
`define SLCC_OFS_CNT_MID 10'h20A
`define SLCC_OFS_CTRL 10'h20C
`define SLCC_OFS_DIV 10'h211
`define SLCC_OFS_INT_STAT 10'h230
`define SLCC_OFS_INT_MASK 10'h231

`define SLCC_SRC_MSB 7
`define SLCC_SRC_LSB 6
`define SLCC_SRC_INT100K 2'h2
`define SLCC_SRC_EXT32K 2'h1
`define SLCC_TUNE_BIT 4
`define SLCC_DONE_BIT 7
`define SLCC_START_BIT 4
`define SLCC_CNT_HI_MSB 3
`define SLCC_INT_DONE_BIT 0

`define SLCC_RST_SRC 2'h0
`define SLCC_RST_TUNE 1'h0
`define SLCC_RST_DIV 5'h00
`define SLCC_RST_CNT 20'h00000
`define SLCC_RST_BYTE 8'h00

`define SLCC_CLK_MHZ 25
`define SLCC_CLK_NS (1000 / `SLCC_CLK_MHZ)
`define SLCC_TICK_NS 50
`define SLCC_PERIODS 16

`endif

/* slcc_sync.sv */
// Purpose: Two-stage synchroniser for an oscillator pin.
// Assumes: The pin is asynchronous to sys_clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module slcc_sync (
	input wire logic sys_clk, // System clock.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic async_in, // Asynchronous pin level.
	output logic sync_out // Level in the sys_clk domain.
);

	logic meta_r;
	logic sync_r;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule // slcc_sync

`default_nettype wire

/* slcc_tb_top.sv */
// Purpose: Self-checking bench for the sleep clock calibration block.
// Assumes: 25 MHz sys_clk; both oscillator pins run free at their nominal rates.
// Notes: Counts are checked against the ideal tick figure with a two-tick margin for pin synchronisation.
`timescale 1ns/1ps
`default_nettype none
`include "slcc_regs.svh"

module slcc_tb_top import slcc_pkg::*;;
	localparam int LIMIT = 50000;
	logic sys_clk;
	logic nrst;
	logic osc100k_pin;
	logic osc32k_pin;
	slcc_bus_req_t bus_req;
	logic [7:0] rd_data;
	logic [1:0] lowpower_clock_source;
	logic oscillator_tuning_bit;
	logic lowpower_clock;
	logic calibration_busy;
	logic irq;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int lp_cnt = 0;
	int p0;
	logic [7:0] rv;
	logic [9:0] regs [9] = '{`SLCC_OFS_SRC_SEL, `SLCC_OFS_TUNE, `SLCC_OFS_CNT_LO, `SLCC_OFS_CNT_MID,
		`SLCC_OFS_CTRL, `SLCC_OFS_DIV, `SLCC_OFS_INT_STAT, `SLCC_OFS_INT_MASK, 10'h20B};

	slcc_top slcc_top_inst (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.osc100k_pin(osc100k_pin),
		.osc32k_pin(osc32k_pin),
		.lowpower_clock_source(lowpower_clock_source),
		.oscillator_tuning_bit(oscillator_tuning_bit),
		.lowpower_clock(lowpower_clock),
		.calibration_busy(calibration_busy),
		.irq(irq)
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// The oscillators are free running and unrelated to sys_clk.
	initial begin
		osc100k_pin = 1'b0;
		forever #5000 osc100k_pin = ~osc100k_pin;
	end

	initial begin
		osc32k_pin = 1'b0;
		forever #15625 osc32k_pin = ~osc32k_pin;
	end

	// Low-power pulses are counted on the falling edge, where they are settled.
	always @(negedge sys_clk) begin
		if (lowpower_clock === 1'b1) begin
			lp_cnt++;
		end
	end

	task automatic close_out;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(d, exp);
	endtask

	task automatic measure(input logic [1:0] src, input logic [4:0] div, input int exp, input logic msk,
		input logic restart);
		int n;
		logic [19:0] cnt;
		wr(`SLCC_OFS_SRC_SEL, {src, 6'h00});
		wr(`SLCC_OFS_DIV, {3'h0, div});
		wr(`SLCC_OFS_INT_MASK, {7'h00, msk});
		wr(`SLCC_OFS_CTRL, 8'h10);
		repeat (3) @(posedge sys_clk);
		rd(`SLCC_OFS_CTRL, rv);
		check(rv[7], 1'b0);
		check(rv[4], 1'b0);
		check(calibration_busy, 1'b1);
		if (restart) begin
			repeat (500) @(posedge sys_clk);
			wr(`SLCC_OFS_CTRL, 8'h10);
		end
		n = 0;
		while (calibration_busy !== 1'b0 && n < 40000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		rd(`SLCC_OFS_CTRL, rv);
		check(rv[7], 1'b1);
		cnt[19:16] = rv[3:0];
		rd(`SLCC_OFS_CNT_LO, rv);
		cnt[7:0] = rv;
		rd(`SLCC_OFS_CNT_MID, rv);
		cnt[15:8] = rv;
		check(cnt >= exp - 2 && cnt <= exp + 2, 1'b1);
		check(irq, msk);
		rdchk(`SLCC_OFS_INT_STAT, 8'h01);
		wr(`SLCC_OFS_INT_STAT, 8'h01);
		#1;
		check(irq, 1'b0);
		rdchk(`SLCC_OFS_INT_STAT, 8'h00);
	endtask

	initial begin
		nrst = 1'b0;
		bus_req = '0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (regs[i]) begin
			rdchk(regs[i], 8'h00);
		end
		wr(`SLCC_OFS_SRC_SEL, 8'h80);
		#1;
		check(lowpower_clock_source, `SLCC_SRC_INT100K);
		rdchk(`SLCC_OFS_SRC_SEL, 8'h80);
		wr(`SLCC_OFS_TUNE, 8'h10);
		#1;
		check(oscillator_tuning_bit, 1'b1);
		rdchk(`SLCC_OFS_TUNE, 8'h10);
		// With divisor zero the 100 kHz source gives one pulse per 250 clock cycles.
		p0 = lp_cnt;
		repeat (2500) @(posedge sys_clk);
		check(lp_cnt - p0, 10);
		wr(`SLCC_OFS_SRC_SEL, 8'hC0);
		repeat (2) @(posedge sys_clk);
		p0 = lp_cnt;
		repeat (600) @(posedge sys_clk);
		check(lp_cnt - p0, 0);
		wr(`SLCC_OFS_CNT_LO, 8'hFF);
		wr(`SLCC_OFS_CNT_MID, 8'hFF);
		rdchk(`SLCC_OFS_CNT_LO, 8'h00);
		rdchk(`SLCC_OFS_CNT_MID, 8'h00);
		// One tick is 50 ns, so one period of 16 x (div + 1) source periods gives the figures below.
		measure(`SLCC_SRC_INT100K, 5'h00, 3200, 1'b1, 1'b0);
		measure(`SLCC_SRC_INT100K, 5'h01, 6400, 1'b0, 1'b1);
		measure(`SLCC_SRC_EXT32K, 5'h00, 10000, 1'b1, 1'b0);
		check(lowpower_clock_source, `SLCC_SRC_EXT32K);
		close_out();
	end
endmodule // slcc_tb_top

`default_nettype wire

/* slcc_top.sv */
// Purpose: Sleep clock source selection and calibration counter.
// Assumes: 25 MHz sys_clk; oscillator pins asynchronous to it.
// Notes: Reserved bits are not stored and read back as zero, except in the interrupt mask register, which stores all eight bits.
// Function
// R1: Bits 7:6 pick the source: 10 internal 100 kHz, 01 external 32 kHz.
// R2: Software writes zero to reserved bits 5:0 of the source register.
// R3: Tuning bit 4 resets to 0; software should set it to 1.
// R4: Software keeps reserved tuning register bits 7:5 and 3:0 at zero.
// R5: Count spans 16 consecutive low-power clock periods in a 20-bit value.
// R6: The count advances in 50 ns ticks.
// R7: Count bytes at 0x209, 0x20A, bits 19:16 in control; read-only, reset zero.
// R8: Measured period follows the selected source and five-bit divisor.
// R9: Read-only done flag at control bit 7 sets when counting completes.
// R10: Writing 1 to start bit 4 begins counting; hardware clears it.
// R11: A new start clears the done flag and restarts the count at zero.
`timescale 1ns/1ps
`default_nettype none
`include "slcc_regs.svh"

module slcc_top
	import slcc_pkg::*;
#(
	parameter int CNT_W = 20,
	parameter int DIV_W = 5,
	parameter int PERIODS = `SLCC_PERIODS
) (
	input wire logic sys_clk, // System clock, 25 MHz.
	input wire logic nrst, // Synchronous reset, active low.
	input wire slcc_bus_req_t bus_req, // Register access request.
	output logic [7:0] rd_data, // Read data, one cycle after the read strobe.
	input wire logic osc100k_pin, // Internal 100 kHz oscillator output.
	input wire logic osc32k_pin, // External 32 kHz crystal oscillator output.
	output logic [1:0] lowpower_clock_source, // Selected source code.
	output logic oscillator_tuning_bit, // Oscillator tuning control.
	output logic lowpower_clock, // One-cycle pulse per low-power clock period.
	output logic calibration_busy, // High while a measurement runs.
	output logic irq // Level interrupt.
);

	localparam int PER_W = $clog2(PERIODS);
	localparam logic [6:0] CLK_NS = 7'(`SLCC_CLK_NS);
	localparam logic [6:0] TICK_NS = 7'(`SLCC_TICK_NS);
	localparam logic [PER_W-1:0] LAST_PER = PER_W'(PERIODS - 1);
	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	logic s100;
	logic s32;

	slcc_sync u_sync100 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(osc100k_pin),
		.sync_out(s100)
	);

	slcc_sync u_sync32 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(osc32k_pin),
		.sync_out(s32)
	);

	// Register bank.
	logic [1:0] src_r, src_nxt;
	logic tune_r, tune_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic start_r, start_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [7:0] rd_r, rd_nxt;

	// Measurement state.
	slcc_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [PER_W-1:0] per_r, per_nxt;
	logic done_r, done_nxt;
	logic done_evt;

	// Low-power clock derivation.
	logic src_lvl;
	logic src_prev_r;
	logic src_rise;
	logic [DIV_W-1:0] dcnt_r, dcnt_nxt;
	logic lp_edge;
	logic lp_pulse_r;

	// Tick timebase.
	logic [6:0] acc_r, acc_nxt;
	logic [6:0] acc_sum;
	logic tick;

	logic wr_hit_src, wr_hit_tune, wr_hit_ctrl, wr_hit_div, wr_hit_stat, wr_hit_mask;

	assign wr_hit_src = bus_req.wr && (bus_req.addr == `SLCC_OFS_SRC_SEL);
	assign wr_hit_tune = bus_req.wr && (bus_req.addr == `SLCC_OFS_TUNE);
	assign wr_hit_ctrl = bus_req.wr && (bus_req.addr == `SLCC_OFS_CTRL);
	assign wr_hit_div = bus_req.wr && (bus_req.addr == `SLCC_OFS_DIV);
	assign wr_hit_stat = bus_req.wr && (bus_req.addr == `SLCC_OFS_INT_STAT);
	assign wr_hit_mask = bus_req.wr && (bus_req.addr == `SLCC_OFS_INT_MASK);

	// Reserved bits are not stored and read back as zero, except in the interrupt mask, which stores all eight bits.
	always_comb begin
		src_nxt = wr_hit_src ? bus_req.wdata[`SLCC_SRC_MSB:`SLCC_SRC_LSB] : src_r; // R1
		tune_nxt = wr_hit_tune ? bus_req.wdata[`SLCC_TUNE_BIT] : tune_r; // R3
		div_nxt = wr_hit_div ? bus_req.wdata[DIV_W-1:0] : div_r;
		start_nxt = wr_hit_ctrl && bus_req.wdata[`SLCC_START_BIT]; // R10
		mask_nxt = wr_hit_mask ? bus_req.wdata : mask_r;
		stat_nxt = stat_r & ~(wr_hit_stat ? bus_req.wdata : 8'h00);
		stat_nxt[`SLCC_INT_DONE_BIT] = stat_nxt[`SLCC_INT_DONE_BIT] | done_evt;
		rd_nxt = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`SLCC_OFS_SRC_SEL: rd_nxt = {src_r, 6'h00};
				`SLCC_OFS_TUNE: rd_nxt = {3'h0, tune_r, 4'h0};
				`SLCC_OFS_CNT_LO: rd_nxt = cnt_r[7:0]; // R7
				`SLCC_OFS_CNT_MID: rd_nxt = cnt_r[15:8]; // R7
				`SLCC_OFS_CTRL: rd_nxt = {done_r, 2'h0, start_r, cnt_r[19:16]}; // R9
				`SLCC_OFS_DIV: rd_nxt = 8'(div_r);
				`SLCC_OFS_INT_STAT: rd_nxt = stat_r;
				`SLCC_OFS_INT_MASK: rd_nxt = mask_r;
				default: rd_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			src_r <= `SLCC_RST_SRC;
			tune_r <= `SLCC_RST_TUNE; // R3
			div_r <= `SLCC_RST_DIV;
			start_r <= 1'h0;
			stat_r <= `SLCC_RST_BYTE;
			mask_r <= `SLCC_RST_BYTE;
			rd_r <= `SLCC_RST_BYTE;
		end else begin
			src_r <= src_nxt;
			tune_r <= tune_nxt;
			div_r <= div_nxt;
			start_r <= start_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Only the two documented codes yield a clock; other codes stall it.
	always_comb begin
		case (src_r)
			`SLCC_SRC_INT100K: src_lvl = s100; // R1
			`SLCC_SRC_EXT32K: src_lvl = s32; // R1
			default: src_lvl = 1'h0;
		endcase
	end

	assign src_rise = src_lvl && !src_prev_r;
	// One low-power period spans divisor plus one source periods; a lowered divisor acts at the next edge.
	assign lp_edge = src_rise && (dcnt_r >= div_r); // R8

	always_comb begin
		dcnt_nxt = dcnt_r;
		if (src_rise) begin
			dcnt_nxt = lp_edge ? '0 : dcnt_r + 1'b1; // R8
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			src_prev_r <= 1'h0;
			dcnt_r <= '0;
			lp_pulse_r <= 1'h0;
		end else begin
			src_prev_r <= src_lvl;
			dcnt_r <= dcnt_nxt;
			lp_pulse_r <= lp_edge;
		end
	end

	// A 40 ns clock builds 50 ns ticks by carrying the remainder forward.
	assign acc_sum = acc_r + CLK_NS;
	assign tick = acc_sum >= TICK_NS; // R6

	always_comb begin
		acc_nxt = tick ? acc_sum - TICK_NS : acc_sum; // R6
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			acc_r <= 7'h00;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// Counting opens on a low-power edge and closes on the sixteenth edge after it.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		per_nxt = per_r;
		done_nxt = done_r;
		done_evt = 1'h0;
		if (start_r) begin
			state_nxt = SLCC_ALIGN; // R10
			cnt_nxt = `SLCC_RST_CNT; // R11
			per_nxt = '0;
			done_nxt = 1'h0; // R11
		end else begin
			case (state_r)
				SLCC_IDLE: begin
					state_nxt = SLCC_IDLE;
				end
				SLCC_ALIGN: begin
					if (lp_edge) begin
						state_nxt = SLCC_MEASURE;
					end
				end
				SLCC_MEASURE: begin
					if (tick && cnt_r != CNT_MAX) begin
						cnt_nxt = cnt_r + 1'b1; // R5
					end
					if (lp_edge) begin
						per_nxt = per_r + 1'b1;
						if (per_r == LAST_PER) begin
							state_nxt = SLCC_IDLE; // R5
							done_nxt = 1'h1; // R9
							done_evt = 1'h1;
						end
					end
				end
				default: begin
					state_nxt = SLCC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_r <= SLCC_IDLE;
			cnt_r <= `SLCC_RST_CNT; // R7
			per_r <= '0;
			done_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			done_r <= done_nxt;
		end
	end

	assign rd_data = rd_r;
	assign lowpower_clock_source = src_r;
	assign oscillator_tuning_bit = tune_r;
	assign lowpower_clock = lp_pulse_r;
	assign calibration_busy = (state_r != SLCC_IDLE);
	assign irq = |(stat_r & mask_r);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_start_self_clear: assert property (start_r && !(wr_hit_ctrl && bus_req.wdata[`SLCC_START_BIT]) |=> !start_r) // R10
		else $error("start bit did not clear itself");

	a_restart_clears_done: assert property (start_r |=> (!done_r && cnt_r == 20'h00000 && state_r == SLCC_ALIGN)) // R11
		else $error("start did not clear done and count");

	a_done_after_sixteen: assert property ($rose(done_r) |-> $past(per_r) == 4'hF && $past(lp_edge)) // R5
		else $error("done set without sixteen periods");

	a_tick_spacing: assert property (tick |-> ##[1:2] tick) // R6
		else $error("tick spacing wrong for 50 ns");

	a_edge_needs_source: assert property (lp_edge |-> (src_r == 2'h2 || src_r == 2'h1)) // R1
		else $error("low-power edge from an unselected source");

	a_divisor_spacing: assert property (lp_edge |=> dcnt_r == 5'h00) // R8
		else $error("divisor count not reset after edge");

	a_count_low_read: assert property (bus_req.rd && bus_req.addr == 10'h209 |=> rd_data == $past(cnt_r[7:0])) // R7
		else $error("count low byte read mismatch");

	a_done_flag_read: assert property (bus_req.rd && bus_req.addr == 10'h20C |=> rd_data[7] == $past(done_r)) // R9
		else $error("done flag read mismatch");

	a_tune_write: assert property (bus_req.wr && bus_req.addr == 10'h208 |=> tune_r == $past(bus_req.wdata[4])) // R3
		else $error("tuning bit not written");

	a_status_set_wins: assert property (done_evt |=> stat_r[`SLCC_INT_DONE_BIT]) // R9
		else $error("done status bit not set");

	a_pulse_follows_edge: assert property (lp_edge |=> lowpower_clock) // R8
		else $error("low-power pulse missing after edge");

	a_count_hold_idle: assert property (state_r == SLCC_IDLE && !start_r |=> cnt_r == $past(cnt_r)) // R5
		else $error("count changed while idle");

	a_count_tick_step: assert property (state_r == SLCC_MEASURE && !start_r && tick && cnt_r != CNT_MAX |=> cnt_r == $past(cnt_r) + 20'h00001) // R6
		else $error("count did not advance on a tick");

	a_read_idle_zero: assert property (!bus_req.rd |=> rd_data == 8'h00) // R7
		else $error("read data not zero outside a read");

endmodule // slcc_top

`default_nettype wire
